// ==== src/sdamc_mode_control.sv ====
`timescale 1ns/1ps
module sdamc_mode_control
	import sdamc_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [7:0]              ext_addr,
	input  wire logic                    ext_write,
	input  wire logic                    ext_read,
	input  wire logic [7:0]              ext_wdata,
	output logic      [7:0]              ext_rdata,
	output logic                         ext_rvalid,
	output logic                         converter_power_on,
	output logic                         conversion_enable,
	output logic                         wire_mode_select,
	output logic                         bandgap_output_stop,
	output logic                         bandgap_reference_run,
	output logic                         reference_io_pin_oe,
	output sdamc_pkg::sdamc_gain_t       amp_gain_select,
	input  wire logic [CHANNELS-1:0]     sample_valid,
	input  wire logic [CHANNELS*24-1:0]  sample_data,
	output logic      [CHANNELS*24-1:0]  conversion_result
);
	import sdamc_pkg::*;

	// module state
	typedef struct packed {
		logic [7:0] adc_mode_control; // mode register
		logic [7:0] rdata;            // read data
		logic       rvalid;           // read answer strobe
	} sdamc_state_t;

	sdamc_state_t state;      // registered state
	sdamc_state_t next_state; // next state

	logic hit; // address decode of the mode register

	// decode only the extended register address
	assign hit = (ext_addr == ADC_MODE_CONTROL_ADDR);

	// next state: register write and read answer
	always_comb begin
		next_state        = state;
		next_state.rvalid = ext_read;
		next_state.rdata  = 8'h00;
		if (ext_write && hit) begin
			// unused bits are kept zero whatever is written
			next_state.adc_mode_control =
				ext_wdata & MODE_WRITABLE_MASK;
		end
		if (ext_read && hit) begin
			// stored value comes back unchanged
			next_state.rdata = state.adc_mode_control;
		end
	end

	// register state; any reset clears the mode register
	always_ff @(posedge clk) begin
		if (rst) begin
			state.adc_mode_control <= ADC_MODE_CONTROL_RST;
			state.rdata            <= 8'h00;
			state.rvalid           <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign ext_rdata  = state.rdata;
	assign ext_rvalid = state.rvalid;

	// controls driven straight from the fields
	assign converter_power_on = state.adc_mode_control[POS_POWER_ON];
	assign conversion_enable  =
		state.adc_mode_control[POS_CONV_ENABLE];
	assign wire_mode_select   = state.adc_mode_control[POS_WIRE_MODE];
	assign bandgap_output_stop =
		state.adc_mode_control[POS_BANDGAP_STOP];
	// bandgap runs and the pin drives only with internal reference
	assign bandgap_reference_run = !bandgap_output_stop;
	assign reference_io_pin_oe   = !bandgap_output_stop;
	assign amp_gain_select = state.adc_mode_control[POS_GAIN_SELECT]
		? SDAMC_GAIN_X16 : SDAMC_GAIN_X2;

	// one result register per channel
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_res
			sdamc_result_hold #(.WIDTH(RESULT_WIDTH)) u_res (
				.clk         (clk),
				.rst         (rst),
				.conv_enable (conversion_enable),
				.load        (sample_valid[ch]),
				.load_data   (sample_data[ch*24 +: 24]),
				.result      (conversion_result[ch*24 +: 24])
			);
		end
	endgenerate

	// a write to the mode address lands, reserved bits dropped
	write_updates_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_write && hit |=> state.adc_mode_control
			== ($past(ext_wdata) & MODE_WRITABLE_MASK))
		else $error("mode register did not take write");
	// reserved bits never hold a one
	reserved_zero_a: assert property (@(posedge clk)
		disable iff (rst)
		state.adc_mode_control[4] == 1'b0
		&& state.adc_mode_control[1:0] == 2'b00)
		else $error("reserved mode bits not zero");
	// reset leaves the mode register at its reset value
	reset_clear_a: assert property (@(posedge clk)
		rst |=> state.adc_mode_control == ADC_MODE_CONTROL_RST)
		else $error("mode register not cleared by reset");
	// reset leaves every control at its idle level
	reset_controls_a: assert property (@(posedge clk)
		rst |=> !converter_power_on && !conversion_enable
			&& !wire_mode_select && !bandgap_output_stop
			&& bandgap_reference_run && reference_io_pin_oe
			&& amp_gain_select == SDAMC_GAIN_X2)
		else $error("controls not idle after reset");
	// reset clears every channel result
	reset_results_a: assert property (@(posedge clk)
		rst |=> conversion_result == '0)
		else $error("results not cleared by reset");
	// writes to other addresses leave the mode alone
	other_addr_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_write && !hit |=> $stable(state.adc_mode_control))
		else $error("mode register changed by foreign address");
	// without a mode write the register holds its value
	mode_holds_a: assert property (@(posedge clk)
		disable iff (rst)
		!(ext_write && hit) |=> $stable(state.adc_mode_control))
		else $error("mode register changed without write");
	// power switch follows the written bit 7
	power_field_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_write && hit |=> converter_power_on == $past(ext_wdata[7]))
		else $error("power control does not follow bit 7");
	// conversion enable follows the written bit 6
	enable_field_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_write && hit |=> conversion_enable == $past(ext_wdata[6]))
		else $error("conversion enable does not follow bit 6");
	// wire mode follows the written bit 5
	wire_field_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_write && hit |=> wire_mode_select == $past(ext_wdata[5]))
		else $error("wire mode does not follow bit 5");
	// pin drives and bandgap runs only with internal reference
	ref_pin_a: assert property (@(posedge clk)
		disable iff (rst)
		reference_io_pin_oe == !state.adc_mode_control[3]
		&& bandgap_reference_run == reference_io_pin_oe)
		else $error("reference pin direction wrong");
	// amplifier gain follows the written bit 2
	gain_field_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_write && hit |=> (amp_gain_select == SDAMC_GAIN_X16)
			== $past(ext_wdata[2]))
		else $error("gain does not follow bit 2");
	// a read of the mode address returns the stored value
	read_back_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_read && hit && !ext_write |=> ext_rvalid
			&& ext_rdata == state.adc_mode_control)
		else $error("read does not return stored value");
	// a read of any other address answers zero
	unmapped_read_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_read && !hit |=> ext_rvalid && ext_rdata == 8'h00)
		else $error("foreign address read not zero");
	// every read gets its answer strobe one cycle later
	read_answer_a: assert property (@(posedge clk)
		disable iff (rst)
		ext_read |=> ext_rvalid)
		else $error("read answer strobe missing");
	// no answer strobe without a read
	no_stray_answer_a: assert property (@(posedge clk)
		disable iff (rst)
		!ext_read |=> !ext_rvalid)
		else $error("answer strobe without read");
	// results read zero from the edge after conversion stops
	results_clear_a: assert property (@(posedge clk)
		disable iff (rst)
		!conversion_enable |=> conversion_result == '0)
		else $error("results not clear while stopped");
	// running channel 1 takes its sample on the load pulse
	result_load_a: assert property (@(posedge clk)
		disable iff (rst)
		conversion_enable && sample_valid[1]
		|=> conversion_result[47:24] == $past(sample_data[47:24]))
		else $error("running channel did not load sample");

	// scenarios that the bench is expected to reach

	write_mode_c: cover property (@(posedge clk) ext_write && hit);
	read_mode_c: cover property (@(posedge clk) ext_read && hit);
	conv_run_c: cover property (@(posedge clk)
		conversion_enable && |sample_valid);
	ext_ref_c: cover property (@(posedge clk) bandgap_output_stop);
endmodule : sdamc_mode_control

// ==== common/sdamc_pkg.sv ====
package sdamc_pkg;
	// register address in the extended register space
	localparam logic [7:0] ADC_MODE_CONTROL_ADDR = 8'hA3;
	// reset value of the mode register
	localparam logic [7:0] ADC_MODE_CONTROL_RST  = 8'h00;
	// field positions
	localparam int POS_POWER_ON     = 7;
	localparam int POS_CONV_ENABLE  = 6;
	localparam int POS_WIRE_MODE    = 5;
	localparam int POS_BANDGAP_STOP = 3;
	localparam int POS_GAIN_SELECT  = 2;
	// bits that hold state; the others read zero
	localparam logic [7:0] MODE_WRITABLE_MASK = 8'hEC;
	// width of one conversion result
	localparam int RESULT_WIDTH = 24;
	// reset value of a result
	localparam logic [23:0] RESULT_RST = 24'h000000;
	// amplifier gain codes seen by the analog side
	typedef enum logic {
		SDAMC_GAIN_X2,
		SDAMC_GAIN_X16
	} sdamc_gain_t;
endpackage : sdamc_pkg

// ==== src/sdamc_result_hold.sv ====
`timescale 1ns/1ps
// one channel result register, held clear while conversion is stopped
module sdamc_result_hold
	import sdamc_pkg::*;
#(
	parameter int WIDTH = sdamc_pkg::RESULT_WIDTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             conv_enable,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_data,
	output logic      [WIDTH-1:0] result
);
	// module state
	typedef struct packed {
		logic [WIDTH-1:0] value; // stored result
	} sdamc_hold_state_t;

	sdamc_hold_state_t state;      // registered state
	sdamc_hold_state_t next_state; // next state

	// next value: clear when stopped, else load new sample
	always_comb begin
		next_state = state;
		if (!conv_enable) begin
			next_state.value = '0;
		end else if (load) begin
			next_state.value = load_data;
		end
	end

	// register the state
	always_ff @(posedge clk) begin
		if (rst) begin
			state.value <= WIDTH'(RESULT_RST);
		end else begin
			state <= next_state;
		end
	end

	assign result = state.value;

	// a stopped converter shows a cleared result from the next edge on
	cleared_when_stopped_a: assert property (@(posedge clk)
		disable iff (rst) !conv_enable |=> result == '0)
		else $error("result not cleared while conversion stopped");
endmodule : sdamc_result_hold

// ==== tb/sdamc_core_model.sv ====
`timescale 1ns/1ps
// stand-in for the converter core: one load pulse per fire request
module sdamc_core_model (
	input  wire logic        clk,
	input  wire logic [3:0]  fire,
	input  wire logic [23:0] word,
	output logic      [3:0]  sample_valid,
	output logic      [95:0] sample_data
);
	// data is only good with its pulse; inverted otherwise
	always_ff @(posedge clk) begin
		sample_valid <= fire;
		sample_data  <= {4{(fire != 4'h0) ? word : ~word}};
	end
endmodule : sdamc_core_model

// ==== tb/tb_sigma_delta_adc_mode_control.sv ====
`timescale 1ns/1ps
module tb_sigma_delta_adc_mode_control;
	import sdamc_pkg::*;
	logic        clk, rst, wr, rd, rv;
	logic [7:0]  addr, wd, rdat;
	logic [3:0]  fire, sv;
	logic [23:0] word;
	logic [95:0] sd, res;
	logic        pwr, en, wm, bgs, bandgap_reference, oe;
	sdamc_gain_t gain;
	int          error_cnt = 0;
	int          samples_checked = 0;
	// mode values kept to zero in bits 0, 1 and 4
	logic [7:0]  vals [6] = '{8'hC4, 8'h2C, 8'h80, 8'h48, 8'hEC, 8'h00};
	sdamc_mode_control u_sdamc_mode_control (.clk(clk), .rst(rst),
		.ext_addr(addr), .ext_write(wr), .ext_read(rd), .ext_wdata(wd),
		.ext_rdata(rdat), .ext_rvalid(rv), .converter_power_on(pwr),
		.conversion_enable(en), .wire_mode_select(wm),
		.bandgap_output_stop(bgs), .bandgap_reference_run(bandgap_reference),
		.reference_io_pin_oe(oe), .amp_gain_select(gain),
		.sample_valid(sv), .sample_data(sd), .conversion_result(res));
	sdamc_core_model u_sdamc_core_model (.clk(clk), .fire(fire),
		.word(word), .sample_valid(sv), .sample_data(sd));
	// free running 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// compare and count
	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	// single exit of the run
	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	// wait n edges, then step past them
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	// one write strobe
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask : reg_wr
	// one read strobe, bounded wait for the answer
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		int i;
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		for (i = 0; i < 4 && rv !== 1'b1; i++)
			tick(1);
		if (i == 4) begin
			error_cnt++;
			report_and_stop();
		end else begin
			check({88'h0, rdat}, {88'h0, exp});
			tick(1);
		end
	endtask : reg_rd
	// control outputs against a mode value
	task automatic chk_ctl(input logic [7:0] m);
		check({89'h0, pwr, en, wm, bgs, bandgap_reference, oe, gain},
			{89'h0, m[7], m[6], m[5], m[3], ~m[3], ~m[3], m[2]});
	endtask : chk_ctl
	// main sequence
	initial begin
		{rst, wr, rd, addr, wd, fire, word} = {1'b1, 46'h0};
		tick(16);
		rst = 1'b0;
		chk_ctl(8'h00);
		reg_rd(8'hA3, 8'h00);
		foreach (vals[k]) begin
			reg_wr(8'hA3, vals[k]);
			chk_ctl(vals[k] & 8'hEC);
			reg_rd(8'hA3, vals[k] & 8'hEC);
		end
		// a reset in mid-run clears the mode again
		reg_wr(8'hA3, 8'hC4);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chk_ctl(8'h00);
		reg_rd(8'hA3, 8'h00);
		// other addresses neither store nor disturb the mode
		reg_wr(8'hA3, 8'h44);
		reg_wr(8'hA5, 8'hFF);
		reg_rd(8'hA5, 8'h00);
		reg_rd(8'hA3, 8'h44);
		// load channels 1 and 3 while running, then stop
		reg_wr(8'hA3, 8'hC0);
		word = 24'h123456;
		fire = 4'b1010;
		tick(1);
		fire = 4'h0;
		tick(2);
		check(res, {word, 24'h0, word, 24'h0});
		reg_wr(8'hA3, 8'h80);
		tick(1);
		check(res, 96'h0);
		// load pulses while stopped leave the results clear
		fire = 4'b0101;
		tick(1);
		fire = 4'h0;
		tick(2);
		check(res, 96'h0);
		report_and_stop();
	end
endmodule : tb_sigma_delta_adc_mode_control
